// ---- pkg/watch_map.svh ----
// Constants for the 3.5 digit duplexed LCD watch: rates, timing counts, ranges.
// Assumes a single system clock at CLK_HZ; included by the switch filter and the core.
`ifndef WATCH_MAP_SVH
`define WATCH_MAP_SVH

// Clock and timebase
`define CLK_HZ 10000000
`define BASE_HZ 1024
`define CHAIN_W 10
// Chain bit that toggles at 2 Hz and at 1 Hz
`define BIT_2HZ 8
`define BIT_1HZ 9
// Chain bits giving four 32 Hz LCD phases
`define PH_LO 3
`define PH_HI 4

// Debounce interval in microseconds, then in base ticks (rounded down)
`define DEB_US 62500
`define DEB_TICKS ((`DEB_US * `BASE_HZ) / 1000000)
// Display hold / alternation / double press window, seconds and ticks
`define VIEW_S 2
`define VIEW_TICKS (`VIEW_S * `BASE_HZ)
// Auto repeat at 2 Hz while a switch is held
`define REP_HZ 2
`define REP_TICKS (`BASE_HZ / `REP_HZ)

// Counter limits and reset values
`define SEC_MAX 7'h3B
`define SEC_ROUND 7'h1E
`define MIN_MAX 7'h3B
`define HR_MAX 7'h17
`define HR_NOON 7'h0C
`define MON_MAX 7'h0C
`define DATE_RST 7'h01
`define MON_RST 7'h01

// Digit codes beyond decimal
`define CODE_A 4'hA
`define CODE_P 4'hB
`define CODE_BLANK 4'hF

`endif

// ---- pkg/watch_pkg.sv ----
// Types shared by the watch core and its switch filter.
// Assumes watch_map.svh on the include path.
package watch_pkg;

    // Display and setting states, Gray coded along the setting path
    typedef enum logic [3:0] {
        ST_NORM = 4'h0,
        ST_ALT = 4'h1,
        ST_SMON = 4'h3,
        ST_SDATE = 4'h2,
        ST_SHR = 4'h6,
        ST_SMIN = 4'h7,
        ST_HOLD = 4'h5,
        ST_CAL = 4'h4,
        ST_SECV = 4'hC
    } wstate_t;

    // Four digit codes plus colon
    typedef struct packed {
        logic [3:0] d1;
        logic [3:0] d2;
        logic [3:0] d3;
        logic [3:0] d4;
        logic colon;
    } disp_t;

    // Debounced switch view
    typedef struct packed {
        logic level;
        logic press;
    } sw_t;

endpackage

// ---- src/switch_filter.sv ----
// Switch input filter: two flop synchroniser, then stability debounce.
// Assumes a one cycle timebase tick from the core on the same clock.
`timescale 1ns/1ns
`include "watch_map.svh"

module switch_filter import watch_pkg::*; (
    input wire logic mclk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic tick, // Base tick pulse
    input wire logic raw, // Switch pin, high when pressed
    output sw_t sw_q // Debounced level and press pulse
);

    logic sync1_q; // First synchroniser stage
    logic sync2_q; // Second synchroniser stage
    logic [6:0] stab_q; // Ticks the input has differed

    ////////////////////////////////////////////////////////////////////////
    // Synchroniser
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accept a new level once it has stood for the debounce interval
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stab_q <= 7'h00;
            sw_q <= '0;
        end else begin
            sw_q.press <= 1'b0;
            if (sync2_q == sw_q.level) begin
                stab_q <= 7'h00; // Bounce back restarts the wait
            end else if (tick) begin
                if (stab_q == 7'(`DEB_TICKS - 1)) begin
                    stab_q <= 7'h00;
                    sw_q.level <= sync2_q;
                    sw_q.press <= sync2_q;
                end else begin
                    stab_q <= stab_q + 7'h01;
                end
            end
        end
    end

endmodule

// ---- src/watch_core.sv ----
// Watch core: timebase, calendar counters, display state machine, LCD drive.
// Assumes switch pins pulled low when open and a 10 MHz system clock.
//
// How it works
// - Divide clock into ticks advancing time counters
// - Output 512 Hz pulse for voltage doubler
// - Normal shows hour:minute, colon toggling 1 Hz
// - Display switch shows month-date, 2 s after release
// - Two presses within 2 s show seconds
// - Set held in seconds view zeroes seconds, rounds
// - Display switch in seconds view returns normal
// - Set in normal alternates time and date 2 s
// - Five set presses from alternating reach normal
// - Display switch in alternating gives seconds view
// - Setting states show only the field set
// - Press adds one; holding repeats at 2 Hz
// - First set step selects month, digits 1-2
// - Next selects date in digits 3-4
// - Next selects hour, A/P, colon 1 Hz
// - Next selects minute; advancing suspends timekeeping
// - Minute colon toggles until minute changed
// - Changed minute leads to hold state, colon steady
// - Unchanged minute returns straight to normal
// - Field being set ignores lower carries
// - Debounce switches no longer than 62.5 ms
// - Duplex LCD drive, two backplanes, 32 Hz frame
`timescale 1ns/1ns
`include "watch_map.svh"

module watch_core import watch_pkg::*; #(
    parameter int unsigned BASE_DIV = `CLK_HZ / `BASE_HZ // Clocks per base tick
) (
    input wire logic mclk, // System clock, 10 MHz
    input wire logic rst_b, // Async reset, active low
    input wire logic disp_sw, // Display switch pin
    input wire logic set_sw, // Set switch pin
    output logic pulse_512_q, // Voltage doubler pump clock
    output logic [1:0] com_q, // Backplane drives
    output logic [11:0] seg_q // Segment drives
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions
    function automatic logic [6:0] seg7(input logic [3:0] code);
        unique case (code)
            4'h0: seg7 = 7'h3F;
            4'h1: seg7 = 7'h06;
            4'h2: seg7 = 7'h5B;
            4'h3: seg7 = 7'h4F;
            4'h4: seg7 = 7'h66;
            4'h5: seg7 = 7'h6D;
            4'h6: seg7 = 7'h7D;
            4'h7: seg7 = 7'h07;
            4'h8: seg7 = 7'h7F;
            4'h9: seg7 = 7'h6F;
            4'hA: seg7 = 7'h77; // Letter A
            4'hB: seg7 = 7'h73; // Letter P
            default: seg7 = 7'h00; // Blank
        endcase
    endfunction

    // Tens and units of a value below 100
    function automatic logic [7:0] to_bcd(input logic [6:0] v);
        logic [6:0] t;
        t = v / 7'd10;
        to_bcd = {t[3:0], 4'(v - t * 7'd10)};
    endfunction

    // Days in month, four year leap cycle
    function automatic logic [6:0] mdays(input logic [6:0] m, input logic [1:0] yr);
        if (m == 7'h02) begin
            mdays = (yr == 2'h0) ? 7'h1D : 7'h1C;
        end else if (m == 7'h04 || m == 7'h06 || m == 7'h09 || m == 7'h0B) begin
            mdays = 7'h1E;
        end else begin
            mdays = 7'h1F;
        end
    endfunction

    // Step a field, wrapping from top back to bottom
    function automatic logic [6:0] step(input logic [6:0] v, input logic [6:0] lo,
                                        input logic [6:0] hi);
        step = (v >= hi) ? lo : v + 7'h01;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [13:0] pre_q; // Prescaler to base tick
    logic tick_q; // One cycle base tick
    logic [`CHAIN_W-1:0] chain_q; // Binary divider chain
    logic sec_tick; // One second pulse
    sw_t dsw; // Display switch
    sw_t ssw; // Set switch
    wstate_t state_q; // Display state
    logic [6:0] sec_q, min_q, hr_q, date_q, mon_q; // Time counters
    logic [1:0] yr_q; // Year in leap cycle
    logic min_chg_q; // Minute changed, timekeeping halted
    logic [11:0] view_q; // Calendar view timer
    logic [11:0] dwin_q; // Double press window
    logic [11:0] alt_q; // Alternation timer
    logic alt_date_q; // Alternating view shows date
    logic [9:0] rep_q; // Auto repeat timer
    logic adv; // Advance selected field
    logic setting; // In a field setting state
    logic round_up; // Seconds reset rounds minute up
    logic bump_min, bump_hr, bump_date, bump_mon; // Carries
    disp_t disp; // Digits to show
    logic [23:0] segs; // Lit segments
    logic [1:0] phase; // LCD phase

    ////////////////////////////////////////////////////////////////////////
    // Switch filters
    switch_filter u_dsw (
        .mclk(mclk),
        .rst_b(rst_b),
        .tick(tick_q),
        .raw(disp_sw),
        .sw_q(dsw)
    );

    switch_filter u_ssw (
        .mclk(mclk),
        .rst_b(rst_b),
        .tick(tick_q),
        .raw(set_sw),
        .sw_q(ssw)
    );

    ////////////////////////////////////////////////////////////////////////
    // Timebase: prescaler then binary chain
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pre_q <= 14'h0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (pre_q == 14'(BASE_DIV - 1));
            pre_q <= (pre_q == 14'(BASE_DIV - 1)) ? 14'h0000 : pre_q + 14'h0001;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            chain_q <= '0;
            pulse_512_q <= 1'b0;
        end else if (tick_q) begin
            chain_q <= chain_q + `CHAIN_W'(1);
            pulse_512_q <= ~chain_q[0];
        end
    end

    assign sec_tick = tick_q && (&chain_q);

    ////////////////////////////////////////////////////////////////////////
    // Advance requests and carries
    assign setting = (state_q == ST_SMON) || (state_q == ST_SDATE) ||
                     (state_q == ST_SHR) || (state_q == ST_SMIN);
    assign adv = setting && (dsw.press || (dsw.level && tick_q &&
                 rep_q == 10'(`REP_TICKS - 1)));
    assign round_up = (state_q == ST_SECV) && ssw.press && (sec_q > `SEC_ROUND);
    assign bump_min = round_up || (sec_tick && !min_chg_q && sec_q == `SEC_MAX &&
                      !(state_q == ST_SECV && ssw.level));
    assign bump_hr = bump_min && min_q == `MIN_MAX && state_q != ST_SMIN;
    assign bump_date = bump_hr && hr_q == `HR_MAX && state_q != ST_SHR;
    assign bump_mon = bump_date && date_q == mdays(mon_q, yr_q) && state_q != ST_SDATE;

    // Auto repeat timer runs while display switch is held
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rep_q <= 10'h000;
        end else if (!dsw.level || dsw.press) begin
            rep_q <= 10'h000;
        end else if (tick_q) begin
            rep_q <= (rep_q == 10'(`REP_TICKS - 1)) ? 10'h000 : rep_q + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Seconds counter
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sec_q <= 7'h00;
        end else if (state_q == ST_SECV && ssw.level) begin
            sec_q <= 7'h00;
        end else if (state_q == ST_HOLD && ssw.press) begin
            sec_q <= 7'h00;
        end else if (sec_tick && !min_chg_q) begin
            sec_q <= step(sec_q, 7'h00, `SEC_MAX);
        end
    end

    // Minute counter
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            min_q <= 7'h00;
        end else if (state_q == ST_SMIN && adv) begin
            min_q <= step(min_q, 7'h00, `MIN_MAX);
        end else if (bump_min && state_q != ST_SMIN) begin
            min_q <= step(min_q, 7'h00, `MIN_MAX);
        end
    end

    // Hour counter
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hr_q <= 7'h00;
        end else if (state_q == ST_SHR && adv) begin
            hr_q <= step(hr_q, 7'h00, `HR_MAX);
        end else if (bump_hr && state_q != ST_SHR) begin
            hr_q <= step(hr_q, 7'h00, `HR_MAX);
        end
    end

    // Date counter
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            date_q <= `DATE_RST;
        end else if (state_q == ST_SDATE && adv) begin
            date_q <= step(date_q, 7'h01, mdays(mon_q, yr_q));
        end else if (bump_date && state_q != ST_SDATE) begin
            date_q <= step(date_q, 7'h01, mdays(mon_q, yr_q));
        end
    end

    // Month counter and year in leap cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mon_q <= `MON_RST;
            yr_q <= 2'h0;
        end else if (state_q == ST_SMON && adv) begin
            mon_q <= step(mon_q, 7'h01, `MON_MAX);
        end else if (bump_mon && state_q != ST_SMON) begin
            mon_q <= step(mon_q, 7'h01, `MON_MAX);
            if (mon_q == `MON_MAX) begin
                yr_q <= yr_q + 2'h1;
            end
        end
    end

    // Minute changed flag halts timekeeping until hold is left
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            min_chg_q <= 1'b0;
        end else if (state_q == ST_SMIN && adv) begin
            min_chg_q <= 1'b1;
        end else if (state_q == ST_HOLD && ssw.press) begin
            min_chg_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // View timers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            view_q <= 12'h000;
        end else if (state_q != ST_CAL || dsw.level) begin
            view_q <= 12'h000;
        end else if (tick_q) begin
            view_q <= view_q + 12'h001;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dwin_q <= 12'h000;
        end else if (state_q == ST_NORM && dsw.press) begin
            dwin_q <= 12'h000;
        end else if (tick_q && dwin_q != 12'(`VIEW_TICKS)) begin
            dwin_q <= dwin_q + 12'h001;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            alt_q <= 12'h000;
            alt_date_q <= 1'b0;
        end else if (state_q != ST_ALT) begin
            alt_q <= 12'h000;
            alt_date_q <= 1'b0;
        end else if (tick_q) begin
            if (alt_q == 12'(`VIEW_TICKS - 1)) begin
                alt_q <= 12'h000;
                alt_date_q <= ~alt_date_q;
            end else begin
                alt_q <= alt_q + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Display state machine
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_NORM;
        end else begin
            unique case (state_q)
                ST_NORM: begin
                    if (dsw.press) begin
                        state_q <= ST_CAL;
                    end else if (ssw.press) begin
                        state_q <= ST_ALT;
                    end
                end
                ST_CAL: begin
                    if (dsw.press && dwin_q < 12'(`VIEW_TICKS)) begin
                        state_q <= ST_SECV;
                    end else if (view_q == 12'(`VIEW_TICKS)) begin
                        state_q <= ST_NORM;
                    end
                end
                ST_SECV: if (dsw.press) state_q <= ST_NORM;
                ST_ALT: begin
                    if (dsw.press) begin
                        state_q <= ST_SECV;
                    end else if (ssw.press) begin
                        state_q <= ST_SMON;
                    end
                end
                ST_SMON: if (ssw.press) state_q <= ST_SDATE;
                ST_SDATE: if (ssw.press) state_q <= ST_SHR;
                ST_SHR: if (ssw.press) state_q <= ST_SMIN;
                ST_SMIN: begin
                    if (ssw.press) begin
                        state_q <= min_chg_q ? ST_HOLD : ST_NORM;
                    end
                end
                ST_HOLD: if (ssw.press) state_q <= ST_NORM;
                default: state_q <= ST_NORM;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Digit selection
    always_comb begin
        logic [6:0] h12;
        logic [7:0] hb, mb, sb, nb, db;
        h12 = (hr_q == 7'h00) ? `HR_NOON : (hr_q > `HR_NOON) ? hr_q - `HR_NOON : hr_q;
        hb = to_bcd(h12);
        mb = to_bcd(min_q);
        sb = to_bcd(sec_q);
        nb = to_bcd(mon_q);
        db = to_bcd(date_q);
        disp = {hb, mb, chain_q[`BIT_1HZ]};
        unique case (state_q)
            ST_CAL: disp = {nb, db, 1'b0};
            ST_SECV: disp = {`CODE_BLANK, `CODE_BLANK, sb, 1'b1};
            ST_ALT: disp = alt_date_q ? {nb, db, 1'b0} : {hb, mb, chain_q[`BIT_1HZ]};
            ST_SMON: disp = {nb, `CODE_BLANK, `CODE_BLANK, 1'b0};
            ST_SDATE: disp = {`CODE_BLANK, `CODE_BLANK, db, 1'b0};
            ST_SHR: disp = {hb, `CODE_BLANK, (hr_q >= `HR_NOON) ? `CODE_P : `CODE_A,
                            chain_q[`BIT_1HZ]};
            ST_SMIN: disp = {`CODE_BLANK, `CODE_BLANK, mb,
                             min_chg_q | chain_q[`BIT_1HZ]};
            ST_HOLD: disp = {hb, mb, 1'b1};
            default: disp = {hb, mb, chain_q[`BIT_1HZ]};
        endcase
        if (disp.d1 == 4'h0) begin
            disp.d1 = `CODE_BLANK; // Half digit shows only a one
        end
    end

    // Segment map: half digit b c, three full digits, colon on top
    assign segs = {disp.colon, seg7(disp.d4), seg7(disp.d3), seg7(disp.d2),
                   (disp.d1 == 4'h1) ? 2'h3 : 2'h0};
    assign phase = chain_q[`PH_HI:`PH_LO];

    ////////////////////////////////////////////////////////////////////////
    // Duplex drive: backplane 0 in first half frame, 1 in second, polarity
    // reversed each quarter so the panel sees no net DC
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            com_q <= 2'h0;
            seg_q <= 12'h000;
        end else begin
            com_q[0] <= phase[1] ? ~phase[0] : phase[0];
            com_q[1] <= phase[1] ? phase[0] : ~phase[0];
            for (int i = 0; i < 12; i++) begin
                seg_q[i] <= (phase[1] ? segs[i + 12] : segs[i]) ? ~phase[0] : phase[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_sec_press;
        state_q == ST_SECV && ssw.press;
    endsequence

    AST_TICK_PERIOD: assert property (@(posedge mclk) disable iff (!rst_b)
        tick_q |-> (pre_q == 14'h0000) ##1 !tick_q) else $error("base tick too frequent");
    AST_PUMP: assert property (@(posedge mclk) disable iff (!rst_b)
        $changed(pulse_512_q) |-> $past(tick_q)) else $error("pump moved off tick");
    AST_ROUND_UP: assert property (@(posedge mclk) disable iff (!rst_b)
        s_sec_press and (sec_q > 7'h1E) and (min_q != 7'h3B) |=> min_q == $past(min_q) + 7'h01)
        else $error("minute not rounded up");
    AST_ROUND_30: assert property (@(posedge mclk) disable iff (!rst_b)
        s_sec_press and (sec_q == 7'h1E) and !sec_tick |=> min_q == $past(min_q))
        else $error("minute moved at thirty");
    AST_SEC_HELD: assert property (@(posedge mclk) disable iff (!rst_b)
        state_q == ST_SECV && ssw.level |=> sec_q == 7'h00) else $error("seconds not held");
    AST_HALT: assert property (@(posedge mclk) disable iff (!rst_b)
        min_chg_q && state_q != ST_HOLD |=> $stable(sec_q)) else $error("time ran while set");
    AST_HOLD_PATH: assert property (@(posedge mclk) disable iff (!rst_b)
        state_q == ST_SMIN && ssw.press && min_chg_q |=> state_q == ST_HOLD && disp.colon)
        else $error("hold not entered");
    AST_SKIP_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
        state_q == ST_SMIN && ssw.press && !min_chg_q |=> state_q == ST_NORM)
        else $error("hold entered without change");
    AST_HOLD_EXIT: assert property (@(posedge mclk) disable iff (!rst_b)
        state_q == ST_HOLD && ssw.press |=> state_q == ST_NORM && sec_q == 7'h00 && !min_chg_q)
        else $error("hold exit wrong");
    AST_SET_NO_CARRY: assert property (@(posedge mclk) disable iff (!rst_b)
        state_q == ST_SHR && !adv |=> $stable(hr_q)) else $error("carry into set hour");

endmodule

// ---- tb/watch_user.sv ----
// Far side models: a bouncing push switch user and a duplex panel.
// Assumes switch pins pulled low when open and com phases 1, 2 as 01.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////
// Push switch, bounces before it settles
module push_user (
    input wire logic mclk, // Bench clock
    output logic pin // Switch pin, high pressed
);
    initial pin = 1'b0;
    // Bounce, steady hold, release, rest
    task automatic press(input int on_clk);
        for (int i = 0; i < 4; i++) begin // Short bounces
            @(negedge mclk);
            pin = ~pin;
            repeat ($urandom_range(9, 1)) @(negedge mclk);
        end
        pin = 1'b1;
        repeat (on_clk) @(negedge mclk);
        pin = 1'b0;
        repeat (260) @(negedge mclk);
    endtask
endmodule
//////////////////////////////////////////////////////////////////////
// Panel: lit map of both backplanes, once a frame
module lcd_panel (
    input wire logic mclk, // Bench clock
    input wire logic [1:0] com, // Backplanes
    input wire logic [11:0] seg, // Segment pins
    output logic [23:0] lit, // Lit segments
    output logic fresh // New map ready
);
    logic [1:0] com_q;
    int cnt = 0;
    initial fresh = 1'b0;
    // Mid phase 1 gives com0, mid phase 2 gives com1
    always @(posedge mclk) begin
        fresh <= 1'b0;
        com_q <= com;
        cnt <= (com == 2'b01 && com_q != 2'b01) ? 1 : cnt + 1;
        if (cnt == 8) lit[11:0] <= ~seg;
        if (cnt == 24) begin
            lit[23:12] <= seg;
            fresh <= 1'b1;
        end
    end
endmodule

// ---- tb/lcd_watch_display_and_setting_test.sv ----
// Bench for the watch core: two switch users and a panel.
// Assumes BASE_DIV of 2, so one second is 2048 clocks.
`timescale 1ns/1ns
module lcd_watch_display_and_setting_test import watch_pkg::*;;
    localparam logic [23:0] M34 = 24'h7FFE00; // Digits 3, 4
    localparam logic [23:0] ALL = 24'hFFFFFF; // Whole panel
    typedef struct {logic [23:0] m; logic [23:0] v;} note_t;
    logic mclk;
    logic rst_b;
    logic disp_sw;
    logic set_sw;
    logic pulse_512_q;
    logic [1:0] com_q;
    logic [11:0] seg_q;
    logic [23:0] lit;
    logic fresh;
    logic want;
    note_t notes[$];
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [6:0] gl [4] = '{7'h3F, 7'h06, 7'h5B, 7'h4F}; // Glyphs 0..3
    watch_core #(.BASE_DIV(2)) dut_u (.mclk(mclk), .rst_b(rst_b), .disp_sw(disp_sw),
        .set_sw(set_sw), .pulse_512_q(pulse_512_q), .com_q(com_q), .seg_q(seg_q));
    push_user d_u (.mclk(mclk), .pin(disp_sw));
    push_user s_u (.mclk(mclk), .pin(set_sw));
    lcd_panel p_u (.mclk(mclk), .com(com_q), .seg(seg_q), .lit(lit), .fresh(fresh));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= rst_b ? cyc + 1 : 0;
    function automatic logic [23:0] pair(input int a, input int b);
        return {1'b0, gl[b], gl[a], 9'h000};
    endfunction
    task automatic fail(input string what, input logic [23:0] e, input logic [23:0] g);
        n_errors++;
        $display("ERROR %s expected %h seen %h", what, e, g);
    endtask
    task automatic cmp_view(input note_t n, input logic [23:0] g);
        checks_done++;
        if ((g & n.m) !== n.v) fail("display", n.v, g & n.m);
    endtask
    task automatic cmp_pin(input string what, input logic [1:0] e, input logic [1:0] g);
        checks_done++;
        if (g !== e) fail(what, {22'h0, e}, {22'h0, g});
    endtask
    // Note the expected view, wait for the watcher
    task automatic expect_view(input logic [23:0] m, input logic [23:0] v);
        notes.push_back('{m, v});
        want = 1'b1;
        for (int i = 0; i < 300 && want; i++) @(negedge mclk);
        if (want) fail("frame", 24'h1, 24'h0);
        want = 1'b0;
    endtask
    // Watcher: oldest note against the next frame
    always @(posedge mclk) begin
        if (want && fresh && notes.size() > 0) begin
            cmp_view(notes.pop_front(), lit);
            want <= 1'b0;
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (95000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        logic p;
        logic [1:0] c;
        void'($urandom(50187));
        rst_b = 1'b0;
        want = 1'b0;
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        repeat (3) begin
            p = pulse_512_q;
            repeat (2) @(negedge mclk);
            cmp_pin("pump", {1'b0, ~p}, {1'b0, pulse_512_q});
        end
        c = com_q;
        for (int i = 0; i < 70 && com_q === c; i++) @(negedge mclk);
        c = com_q;
        repeat (31) @(negedge mclk);
        cmp_pin("backplane", c, com_q);
        @(negedge mclk);
        cmp_pin("backplane", ~c, com_q);
        $display("test rates done");
        expect_view(M34, pair(0, 0));
        @(posedge fresh);
        @(negedge mclk);
        p = lit[23];
        repeat (16) @(posedge fresh);
        @(negedge mclk);
        cmp_pin("colon", {1'b0, ~p}, {1'b0, lit[23]});
        d_u.press(60);
        expect_view(M34, pair(0, 0));
        d_u.press(200);
        expect_view(ALL, pair(0, 1) | 24'h18);
        repeat (3400) @(negedge mclk);
        expect_view(ALL, pair(0, 1) | 24'h18);
        repeat (900) @(negedge mclk);
        expect_view(M34, pair(0, 0));
        $display("test normal done");
        d_u.press(200);
        d_u.press(200);
        expect_view(24'h8001FF, 24'h800000);
        repeat (1024) @(negedge mclk);
        expect_view(24'h8001FF, 24'h800000);
        wait (cyc >= 33 * 2048);
        fork
            s_u.press(1500);
            begin
                repeat (700) @(negedge mclk);
                expect_view(M34, pair(0, 0));
            end
        join
        d_u.press(200);
        expect_view(M34, pair(0, 1));
        $display("test seconds done");
        s_u.press(200);
        expect_view(M34, pair(0, 1));
        repeat (4096) @(negedge mclk);
        expect_view(ALL, pair(0, 1) | 24'h18);
        s_u.press(200);
        expect_view(24'h7FFFFF, 24'h000018);
        s_u.press(200);
        d_u.press(1200);
        expect_view(24'h7FFFFF, pair(0, 3));
        repeat (3) s_u.press(200);
        d_u.press(200);
        expect_view(ALL, pair(0, 3) | 24'h18);
        $display("test setting done");
        repeat (2) d_u.press(200);
        s_u.press(200);
        d_u.press(200);
        expect_view(24'h8001FF, 24'h800000);
        d_u.press(200);
        repeat (5) s_u.press(200);
        d_u.press(200);
        expect_view(24'h8001FF, 24'h800000);
        s_u.press(200);
        expect_view(24'hFFFE00, pair(0, 2) | 24'h800000);
        s_u.press(200);
        expect_view(M34, pair(0, 2));
        $display("test hold done");
        tally_and_finish();
    end
endmodule
